/* File: hdl/ook_tx_state_control.v */
// One-pin on-off-keyed transmit state control with an APB config port.
// Function
// RL1 - Exactly four states, one at a time.
// RL2 - Sleep powers down all but edge detector.
// RL3 - Start edge enters start-up, oscillator on.
// RL4 - Stay in start-up for 400 us.
// RL5 - Stay in tuning for 370 us.
// RL6 - Amplifier off, data ignored until tuned.
// RL7 - Transmit keys carrier from data line.
// RL8 - Low for idle timeout returns to sleep.
// RL9 - Start edge polarity is selectable.
// RL10 - Rising mode: driver waits out start-up plus tuning.
// RL11 - Falling mode: driver holds line low.
// RL12 - Falling mode: advance once oscillator settled.
// RL13 - Falling mode: driver restores line high afterwards.
// RL14 - Ramp times zero or one to 1024 us.
// RL15 - Ramp zero reaches level at once.
// RL16 - Ramp down lasts as long as up.
// RL17 - Ramp should not exceed half a symbol.
// RL18 - Power -10 to +13 dBm, 1 dB steps.
// RL19 - High data restarts idle timeout.
// RL20 - Configuration held constant while active.
`timescale 1ns/1ps
`include "ook_tx_defs.vh"

module ook_tx_state_control (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        data_in,
    output reg         crystal_osc_en,
    output reg         synth_en,
    output reg         output_amplifier_en,
    output reg  [4:0]  output_amplifier_level,
    output reg  [1:0]  state_out
);

    // ************************************************************
    // Data line synchroniser
    // ************************************************************
    reg        sync1_reg;
    reg        sync2_reg;
    reg        sync3_reg;
    reg        line_reg;
    reg        line_prev_reg;
    reg  [2:0] arm_cnt_reg;
    wire       line_armed;

    localparam [2:0] ARM_DONE = `LINE_ARM_CYC;

    // The stages reset low, yet a line that idles high would then look
    // like a rising edge as soon as they fill. Edges are therefore not
    // reported until the stages and the edge register hold the real
    // level. The cost is that a start edge in the first few cycles after
    // reset is missed; a driver has to wait that long anyway.
    assign line_armed = (arm_cnt_reg == ARM_DONE);

    // A change counts only once the second and third stages agree.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg     <= 1'b0;
            sync2_reg     <= 1'b0;
            sync3_reg     <= 1'b0;
            line_reg      <= 1'b0;
            line_prev_reg <= 1'b0;
            arm_cnt_reg   <= 3'h0;
        end else begin
            sync1_reg     <= data_in;
            sync2_reg     <= sync1_reg;
            sync3_reg     <= sync2_reg;
            if (sync2_reg == sync3_reg)
                line_reg <= sync3_reg;
            line_prev_reg <= line_reg;
            if (!line_armed)
                arm_cnt_reg <= arm_cnt_reg + 3'h1;
        end
    end

    // ************************************************************
    // Configuration register
    // ************************************************************
    reg  [31:0] config_reg;
    wire [1:0]  state_w;
    wire        cfg_falling = config_reg[`CFG_EDGE_BIT];
    wire [3:0]  cfg_idle    = config_reg[`CFG_IDLE_LSB +: 4];
    wire [3:0]  cfg_ramp    = config_reg[`CFG_RAMP_LSB +: 4];
    wire [4:0]  cfg_power   = config_reg[`CFG_POWER_LSB +: 5];
    wire        apb_write   = psel & penable & pwrite & pready;
    wire        in_sleep    = (state_w == `ST_SLEEP);

    // Legal limits of each field; a written value outside them is pulled
    // to the nearest limit instead of being refused.
    localparam [3:0] IDLE_LO   = `IDLE_MIN_STEPS;
    localparam [3:0] IDLE_HI   = `IDLE_MAX_STEPS;
    localparam [3:0] RAMP_TOP  = `RAMP_MAX_SEL;
    localparam [4:0] POWER_TOP = `POWER_MAX_DBM - `POWER_MIN_DBM;

    // Clamped copies of the written fields.
    wire [3:0]  wr_idle   = pwdata[`CFG_IDLE_LSB +: 4];
    wire [3:0]  wr_ramp   = pwdata[`CFG_RAMP_LSB +: 4];
    wire [4:0]  wr_power  = pwdata[`CFG_POWER_LSB +: 5];
    wire [3:0]  idle_fit  = (wr_idle < IDLE_LO) ? IDLE_LO :
                            (wr_idle > IDLE_HI) ? IDLE_HI : wr_idle;
    wire [3:0]  ramp_fit  = (wr_ramp > RAMP_TOP) ? RAMP_TOP : wr_ramp;
    wire [4:0]  power_fit = (wr_power > POWER_TOP) ? POWER_TOP : wr_power;

    // Writes while a cycle runs are dropped so settings stay fixed.
    // Out-of-range fields are clamped to the nearest legal value.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= `CFG_RESET;
        end else if (apb_write && paddr == `ADDR_CONFIG && in_sleep) begin
            config_reg <= 32'h0;
            config_reg[`CFG_EDGE_BIT] <= pwdata[`CFG_EDGE_BIT]; // see RL9
            config_reg[`CFG_IDLE_LSB +: 4]  <= idle_fit;
            config_reg[`CFG_RAMP_LSB +: 4]  <= ramp_fit; // see RL14
            config_reg[`CFG_POWER_LSB +: 5] <= power_fit; // see RL18
        end // see RL20
    end

    // ************************************************************
    // Working state machine
    // ************************************************************
    localparam [1:0] S_SLEEP = `ST_SLEEP;
    localparam [1:0] S_OSC   = `ST_OSC_START;
    localparam [1:0] S_TUNE  = `ST_TUNE;
    localparam [1:0] S_TX    = `ST_TRANSMIT;
    localparam [25:0] OSC_CYC  = `OSC_SETTLE_CYC;
    localparam [25:0] TUNE_CYC = `TUNE_LOCK_CYC;
    localparam [25:0] STEP_CYC = `IDLE_STEP_CYC;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [25:0] timer_reg;
    reg  [25:0] timer_next;
    wire [25:0] idle_limit = STEP_CYC * {22'h0, cfg_idle};
    wire        rise_seen  = line_armed & line_reg & ~line_prev_reg;
    wire        fall_seen  = line_armed & ~line_reg & line_prev_reg;
    wire        start_seen = cfg_falling ? fall_seen : rise_seen;

    assign state_w = state_reg;

    // The timer counts cycles within the present state and is cleared on
    // every change of state. Start-up and tuning end on a fixed count;
    // transmit ends only after an unbroken low line of the chosen length.
    // Edges that arrive outside sleep are not looked at, so a busy line
    // cannot restart a cycle that is already running.
    // One state register with four codes keeps exactly one state active.
    always @* begin
        state_next = state_reg; // see RL1
        timer_next = timer_reg + 26'h1;
        case (state_reg)
            S_SLEEP: begin
                timer_next = 26'h0;
                if (start_seen)
                    state_next = S_OSC; // see RL2, RL3
            end
            S_OSC: begin
                if (timer_reg == OSC_CYC - 26'h1) begin
                    state_next = S_TUNE; // see RL4, RL12
                    timer_next = 26'h0;
                end
            end
            S_TUNE: begin
                if (timer_reg == TUNE_CYC - 26'h1) begin
                    state_next = S_TX; // see RL5
                    timer_next = 26'h0;
                end
            end
            S_TX: begin
                if (line_reg) begin
                    timer_next = 26'h0; // see RL19
                end else if (timer_reg == idle_limit - 26'h1) begin
                    state_next = S_SLEEP; // see RL8
                    timer_next = 26'h0;
                end
            end
            default: begin
                state_next = S_SLEEP;
                timer_next = 26'h0;
            end
        endcase
    end

    // State and timer registers; reset puts the block back to sleep.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_SLEEP;
            timer_reg <= 26'h0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    // ************************************************************
    // Amplifier ramp
    // ************************************************************
    // The ramp walks a fraction counter from zero to full in the
    // configured time and back down in the same time.
    // Settings above the longest ramp never reach here, as writes clamp.
    localparam [5:0] UNIT_LAST = `RAMP_UNIT_CYC - 1;
    reg  [15:0] ramp_pos_reg;
    reg  [5:0]  unit_cnt_reg;
    wire [10:0] ramp_len = (cfg_ramp == 4'h0) ? 11'h0 :
                           (11'h1 << (cfg_ramp - 4'h1));
    wire        key_on   = (state_reg == S_TX) & line_reg; // see RL6, RL7
    wire [15:0] ramp_full = {5'h0, ramp_len};
    wire        unit_tick = (unit_cnt_reg == UNIT_LAST);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_pos_reg <= 16'h0;
            unit_cnt_reg <= 6'h0;
        end else begin
            unit_cnt_reg <= unit_tick ? 6'h0 : unit_cnt_reg + 6'h1;
            if (ramp_len == 11'h0) begin
                ramp_pos_reg <= 16'h0; // see RL15
            end else if (unit_tick) begin
                if (key_on && ramp_pos_reg < ramp_full)
                    ramp_pos_reg <= ramp_pos_reg + 16'h1;
                else if (!key_on && ramp_pos_reg != 16'h0)
                    ramp_pos_reg <= ramp_pos_reg - 16'h1; // see RL16
            end
        end
    end

    // Scale the set level by ramp fraction; zero ramp means full step.
    wire [20:0] scaled = {16'h0, cfg_power} * {5'h0, ramp_pos_reg};
    wire [20:0] level_r = (ramp_len == 11'h0) ? {16'h0, cfg_power} :
                          scaled / {10'h0, ramp_len};
    wire        amp_on  = (ramp_len == 11'h0) ? key_on :
                          (ramp_pos_reg != 16'h0) | key_on;

    // ************************************************************
    // Output flops
    // ************************************************************
    // Every output is a flop fed from the present state, so the pins
    // change one cycle after the state register and never glitch.
    // The level reads zero outside transmit even while a ramp winds down.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crystal_osc_en         <= 1'b0;
            synth_en               <= 1'b0;
            output_amplifier_en    <= 1'b0;
            output_amplifier_level <= 5'h0;
            state_out              <= S_SLEEP;
        end else begin
            crystal_osc_en         <= (state_reg != S_SLEEP); // see RL3
            synth_en               <= (state_reg == S_TUNE) |
                                      (state_reg == S_TX);
            output_amplifier_en    <= amp_on & (state_reg == S_TX);
            output_amplifier_level <= (state_reg == S_TX) ?
                                      level_r[4:0] : 5'h0; // see RL18
            state_out              <= state_reg;
        end
    end

    // ************************************************************
    // APB slave: one wait state, error on unmapped address
    // ************************************************************
    // Every access takes one wait state: pready rises in the cycle after
    // the first access cycle and stands for one cycle only. Read data is
    // registered with it, so no combinational path runs from paddr to
    // prdata. An unmapped offset answers with pslverr rather than data.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            case (paddr)
                `ADDR_CONFIG: prdata <= config_reg;
                `ADDR_STATUS: prdata <= {24'h0, 1'b0, line_reg,
                                         amp_on, 3'h0, state_reg};
                `ADDR_LEVEL:  prdata <= {27'h0, output_amplifier_level};
                `ADDR_IDENT:  prdata <= `IDENT_VALUE;
                default:      pslverr <= 1'b1;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

/* File: hdl/ook_tx_defs.vh */
// Constants for the one-pin on-off-keyed transmit state control block.
`ifndef OOK_TX_DEFS_VH
`define OOK_TX_DEFS_VH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define CLK_MHZ           50
`define OSC_SETTLE_US     400
`define OSC_SETTLE_CYC    (`OSC_SETTLE_US * `CLK_MHZ)
`define TUNE_LOCK_US      370
`define TUNE_LOCK_CYC     (`TUNE_LOCK_US * `CLK_MHZ)
`define IDLE_STEP_MS      10
`define IDLE_STEP_CYC     (`IDLE_STEP_MS * 1000 * `CLK_MHZ)
`define IDLE_MIN_STEPS    2
`define IDLE_MAX_STEPS    9
`define RAMP_UNIT_US      1
`define RAMP_UNIT_CYC     (`RAMP_UNIT_US * `CLK_MHZ)
`define RAMP_MAX_SEL      11
`define POWER_MIN_DBM     (-10)
`define POWER_MAX_DBM     13
`define LINE_ARM_CYC      5

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define ADDR_CONFIG       12'h000
`define ADDR_STATUS       12'h004
`define ADDR_LEVEL        12'h008
`define ADDR_IDENT        12'h00C

// Configuration fields.
`define CFG_EDGE_BIT      0
`define CFG_IDLE_LSB      4
`define CFG_RAMP_LSB      8
`define CFG_POWER_LSB     16
// Reset: rising start, shortest idle timeout, no ramp, top power code.
`define CFG_RESET         32'h0017_0020
// The identification value is arbitrary.
`define IDENT_VALUE       32'h0000_5A01

// States.
`define ST_SLEEP          2'h0
`define ST_OSC_START      2'h1
`define ST_TUNE           2'h2
`define ST_TRANSMIT       2'h3

`endif

/* File: dv/ook_tx_sva.sv */
// Port checker for the transmit state control block.
`timescale 1ns/1ps
`include "ook_tx_defs.vh"
module ook_tx_sva (
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       data_in,
    input wire       crystal_osc_en,
    input wire       synth_en,
    input wire       output_amplifier_en,
    input wire [4:0] output_amplifier_level,
    input wire [1:0] state_out
);
    // ****************
    // State dwell, keying, power and APB checks
    // ****************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [1:0]  prev_reg;
    reg [15:0] dwell_reg;
    // Cycles spent in the present state, counted from zero on its second cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg  <= 2'h0;
            dwell_reg <= 16'h0000;
        end else begin
            prev_reg  <= state_out;
            dwell_reg <= (state_out != prev_reg) ? 16'h0000
                                                 : dwell_reg + 16'h0001;
        end
    end
    // Eight cycles cover the input synchroniser and the amplifier flop.
    sequence s_line_high;
        (state_out == 2'h3 && data_in) [*8];
    endsequence
    sequence s_line_low;
        (state_out == 2'h3 && !data_in) [*8];
    endsequence
    a_key_on: assert property (s_line_high |-> output_amplifier_en)
        else $error("amplifier off on high line");
    a_key_off: assert property (s_line_low |-> !output_amplifier_en)
        else $error("amplifier on with low line");
    a_state_order: assert property (state_out != $past(state_out)
        |-> state_out == $past(state_out) + 2'h1)
        else $error("illegal state step");
    a_osc_dwell: assert property (state_out == 2'h2 && prev_reg == 2'h1
        |-> dwell_reg == `OSC_SETTLE_CYC - 1)
        else $error("wrong start-up length");
    a_tune_dwell: assert property (state_out == 2'h3 && prev_reg == 2'h2
        |-> dwell_reg == `TUNE_LOCK_CYC - 1)
        else $error("wrong tuning length");
    a_sleep_quiet: assert property (state_out == 2'h0 && prev_reg == 2'h0
        |-> !crystal_osc_en && !synth_en)
        else $error("power on in sleep");
    a_tune_power: assert property (state_out == 2'h2 && prev_reg == 2'h2
        |-> crystal_osc_en && synth_en)
        else $error("tuning without power");
    a_amp_gated: assert property (state_out != 2'h3 && prev_reg != 2'h3
        |-> !output_amplifier_en && output_amplifier_level == 5'h00)
        else $error("amplifier active before transmit");
    a_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("wait state not kept");
endmodule

/* File: dv/line_driver.sv */
// Model of the encoder that drives the one-wire data line.
`timescale 1ns/1ps
`include "ook_tx_defs.vh"
module line_driver (
    input  wire pclk,
    input  wire go,
    input  wire falling_mode,
    output reg  data_in = 1'b0
);
    localparam int PREP = `OSC_SETTLE_CYC + `TUNE_LOCK_CYC + 40;
    int cnt = 0;
    // Idle level never forms a start edge; payload waits out the margin.
    always @(posedge pclk) begin
        cnt <= go ? cnt + 1 : 0;
        if (!go)
            data_in <= falling_mode;
        else if (cnt < 4)
            data_in <= !falling_mode;
        else if (falling_mode && cnt < `OSC_SETTLE_CYC + 20)
            data_in <= 1'b0;
        else if (cnt < PREP - 80)
            data_in <= ~data_in;
        else if (cnt < PREP)
            data_in <= 1'b0;
        else
            data_in <= cnt[4];
    end
endmodule

/* File: dv/ook_tx_state_control_tb.sv */
// Testbench for the transmit state control block.
`timescale 1ns/1ps
`include "ook_tx_defs.vh"
module ook_tx_state_control_tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg         go = 1'b0;
    reg         falling_mode = 1'b0;
    reg  [31:0] rd;
    reg         err;
    wire [31:0] prdata;
    wire        pready, pslverr, data_in, osc_en, synth_en, amp_en;
    wire [4:0]  amp_level;
    wire [1:0]  state_out;
    int         failures = 0;
    int         n_compared = 0;
    always #10 pclk = ~pclk;
    ook_tx_state_control u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_in(data_in), .crystal_osc_en(osc_en),
        .synth_en(synth_en), .output_amplifier_en(amp_en),
        .output_amplifier_level(amp_level), .state_out(state_out));
    line_driver u_line (.pclk(pclk), .go(go),
        .falling_mode(falling_mode), .data_in(data_in));
    // ****************
    // Tasks
    // ****************
    task automatic wrap_up;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input [31:0] e, input [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    // Holds the request until pready is seen high at a rising edge.
    task automatic apb(input bit wr, input [11:0] a, input [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
            check("pready", 1, 0);
        if (i == 16)
            wrap_up();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_state(input [1:0] s, input int lim);
        for (int i = 0; state_out !== s && i <= lim; i++)
            @(posedge pclk);
        check("state", s, state_out);
        if (state_out !== s)
            wrap_up();
    endtask
    task automatic t_regs;
        apb(0, `ADDR_CONFIG, 0);
        check("config reset", `CFG_RESET, rd);
        apb(0, `ADDR_IDENT, 0);
        check("ident", `IDENT_VALUE, rd);
        apb(0, 12'h010, 0);
        check("unmapped", 1, err);
        apb(1, `ADDR_CONFIG, 32'h0017_0031);
        apb(0, `ADDR_CONFIG, 0);
        check("config", 32'h0017_0031, rd);
        $display("test regs done");
    endtask
    // Idle timeout is a million cycles at least, so reset ends the cycle.
    task automatic t_cycle(input bit fall, input [31:0] cfg, input [4:0] lv);
        apb(1, `ADDR_CONFIG, cfg);
        falling_mode <= fall;
        repeat (20) @(posedge pclk);
        check("wrong edge", 0, state_out);
        go <= 1'b1;
        wait_state(2'h1, 20);
        check("osc", 1, osc_en);
        apb(1, `ADDR_CONFIG, 0);
        apb(0, `ADDR_CONFIG, 0);
        check("config held", cfg, rd);
        wait_state(2'h2, 20100);
        wait_state(2'h3, 18600);
        check("synth", 1, synth_en);
        check("amp early", 0, amp_en);
        apb(0, `ADDR_STATUS, 0);
        check("status", {30'h0, `ST_TRANSMIT}, rd);
        for (int i = 0; i < 100 && data_in !== 1'b1; i++)
            @(posedge pclk);
        repeat (10) @(posedge pclk);
        check("amp on", 1, amp_en);
        check("level", lv, amp_level);
        apb(0, `ADDR_LEVEL, 0);
        check("level reg", {27'h0, lv}, rd);
        repeat (16) @(posedge pclk);
        check("amp off", 0, amp_en);
        go <= 1'b0;
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check("sleep", 0, state_out);
        $display("test cycle done");
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cycle(1'b1, 32'h0017_0031, 5'h17);
        t_cycle(1'b0, 32'h0005_0020, 5'h05);
        wrap_up();
    end
endmodule
bind ook_tx_state_control ook_tx_sva u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .data_in(data_in), .crystal_osc_en(crystal_osc_en),
    .synth_en(synth_en), .output_amplifier_en(output_amplifier_en),
    .output_amplifier_level(output_amplifier_level),
    .state_out(state_out));
